// >>> pda_map.svh
`ifndef PDA_MAP_SVH
`define PDA_MAP_SVH

// Space select levels {sc5, sc4}
`define PDA_SPACE_MEM     2'h3
`define PDA_SPACE_IO      2'h2
`define PDA_SPACE_MSG     2'h1
`define PDA_SPACE_ICN     2'h0

// Width select levels {sc3, sc2}
`define PDA_WSEL_8        2'h3
`define PDA_WSEL_16       2'h2
`define PDA_WSEL_24       2'h1
`define PDA_WSEL_32       2'h0

// Lane masks, bit n is lane n
`define PDA_LANES_B0      4'h1
`define PDA_LANES_B1      4'h2
`define PDA_LANES_W0      4'h3
`define PDA_LANES_W1      4'h6
`define PDA_LANES_T0      4'h7
`define PDA_LANES_ALL     4'hf
`define PDA_LANES_NONE    4'h0

// Defaults
`define PDA_AGENT_WIDTH   32
`define PDA_FIFO_DEPTH    16
`define PDA_MSG_WORDS     2

`endif

// >>> pda_pkg.sv
package pda_pkg;
`include "pda_map.svh"

  // Decoded pattern of one request phase
  typedef struct packed {
    logic       legal;
    logic       seq_ok;
    logic       need32;
    logic [3:0] lanes;
  } pda_pat_type;

  typedef enum logic [1:0] {
    PDA_ERR_NONE,
    PDA_ERR_TNU,
    PDA_ERR_WIDTH
  } pda_err_type;

  // Permitted patterns per space; everything else is illegal
  function automatic pda_pat_type pda_decode(input logic [1:0] space,
                                             input logic [1:0] wsel,
                                             input logic [1:0] alvl);
    pda_pat_type p;
    p = '{legal: 1'b0, seq_ok: 1'b0, need32: 1'b0, lanes: `PDA_LANES_NONE};
    if (space == `PDA_SPACE_MEM || space == `PDA_SPACE_IO) begin
      unique case (wsel)
        `PDA_WSEL_8: begin
          p = '{1'b1, 1'b1, 1'b0, alvl[0] ? `PDA_LANES_B0 : `PDA_LANES_B1};
        end
        `PDA_WSEL_16: begin
          if (alvl[0])
            p = '{1'b1, 1'b1, 1'b0, `PDA_LANES_W0};
          else if (alvl[1])
            p = '{1'b1, 1'b0, 1'b1, `PDA_LANES_W1};
        end
        `PDA_WSEL_24: begin
          // Both 24-bit patterns share one code; lanes 0-2 taken
          if (alvl == 2'h2)
            p = '{1'b1, 1'b0, 1'b1, `PDA_LANES_T0};
        end
        `PDA_WSEL_32: begin
          if (alvl == 2'h3)
            p = '{1'b1, 1'b1, 1'b1, `PDA_LANES_ALL};
        end
      endcase
    end else if (space == `PDA_SPACE_MSG) begin
      if (wsel == `PDA_WSEL_32)
        p = '{1'b1, 1'b1, 1'b1, `PDA_LANES_ALL};
    end else begin
      if (wsel == `PDA_WSEL_8 && alvl == 2'h3)
        p = '{1'b1, 1'b0, 1'b0, `PDA_LANES_B0};
    end
    return p;
  endfunction

  // Expand a lane mask to a 32-bit byte mask
  function automatic logic [31:0] pda_byte_mask(input logic [3:0] lanes);
    return {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
  endfunction

endpackage

// >>> pda_if.sv
`timescale 1ns/1ns
// Request phase and reply handshakes between two agents
interface pda_if;
  logic        req;       // Request phase strobe
  logic [1:0]  space;     // Space select levels
  logic [1:0]  wsel;      // Width select levels
  logic [1:0]  alvl;      // Address bit 1,0 levels
  logic        seq;       // Sequential transfer
  logic [31:0] addr;      // Request address
  logic        dvalid;    // Data beat valid
  logic [31:0] ad;        // Data lanes
  logic        eoc;       // End of cycle on this beat
  logic        ack;       // Reply handshake
  logic        err_tnu;   // Transfer not understood
  logic        err_width; // Width error

  modport requester (output req, space, wsel, alvl, seq, addr, dvalid, ad, eoc,
                     input ack, err_tnu, err_width);
  modport replier   (input req, space, wsel, alvl, seq, addr, dvalid, ad, eoc,
                     output ack, err_tnu, err_width);
endinterface

// >>> pda_req.sv
`timescale 1ns/1ns
`include "pda_map.svh"
module pda_req
  import pda_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  pda_if.requester         bus,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [1:0]  cmd_space,
  input  wire logic [1:0]  cmd_wsel,
  input  wire logic [31:0] cmd_addr,
  input  wire logic        cmd_seq,
  input  wire logic [31:0] cmd_data,
  input  wire logic        cmd_last,
  output logic             rsp_valid,
  output logic [1:0]       rsp_err
);
  import pda_pkg::*;

  typedef enum logic [1:0] {REQ_IDLE, REQ_BEAT, REQ_DONE} pda_req_state_type;

  pda_req_state_type state_r;
  pda_pat_type       pat;
  logic [1:0]        alvl;
  logic [31:0]       steer;
  logic [3:0]        lanes_r;
  logic              refuse;

  // Address bits 0,1 as levels: H means bit clear on the low-true bus
  assign alvl = ~cmd_addr[1:0];
  assign pat  = pda_decode(cmd_space, cmd_wsel, alvl);
  // Own check avoids putting a forbidden pattern on the bus
  assign refuse = !pat.legal || (cmd_seq && !pat.seq_ok) ||
                  (cmd_seq && cmd_wsel == `PDA_WSEL_24) ||
                  (cmd_seq && cmd_space == `PDA_SPACE_ICN);

  // Right-justified user data moved up to its first lane
  always_comb begin
    steer = cmd_data;
    if (lanes_r == `PDA_LANES_B1 || lanes_r == `PDA_LANES_W1)
      steer = {cmd_data[23:0], 8'h00};
  end

  // Transfer sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= REQ_IDLE;
    end else begin
      unique case (state_r)
        REQ_IDLE: if (cmd_valid) state_r <= refuse ? REQ_DONE : REQ_BEAT;
        REQ_BEAT: if (bus.ack && (cmd_last || bus.err_tnu || bus.err_width)) begin
          state_r <= REQ_IDLE;
        end
        REQ_DONE: state_r <= REQ_IDLE;
      endcase
    end
  end

  // Request phase fields, held through the transfer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.req   <= 1'b0;
      bus.space <= `PDA_SPACE_MEM;
      bus.wsel  <= `PDA_WSEL_8;
      bus.alvl  <= 2'h3;
      bus.seq   <= 1'b0;
      bus.addr  <= 32'h0000_0000;
      lanes_r   <= `PDA_LANES_NONE;
    end else begin
      bus.req <= (state_r == REQ_IDLE) && cmd_valid && !refuse;
      if (state_r == REQ_IDLE && cmd_valid) begin
        bus.space <= cmd_space;
        bus.wsel  <= cmd_wsel;
        bus.alvl  <= alvl;
        bus.seq   <= cmd_seq;
        // Message address carries only the two 8-bit agent IDs
        bus.addr  <= (cmd_space == `PDA_SPACE_MSG) ?
                     {16'h0000, cmd_addr[15:0]} : cmd_addr;
        lanes_r   <= pat.lanes;
      end
    end
  end

  // Data beats, withholding end of cycle until the last word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.dvalid <= 1'b0;
      bus.ad     <= 32'h0000_0000;
      bus.eoc    <= 1'b0;
    end else begin
      bus.dvalid <= (state_r == REQ_BEAT) && !bus.ack && !bus.req && cmd_valid;
      bus.ad     <= steer;
      bus.eoc    <= cmd_last;
    end
  end

  // Each beat's answer, or a local refusal
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_err   <= PDA_ERR_NONE;
    end else begin
      rsp_valid <= (state_r == REQ_BEAT && bus.ack) || state_r == REQ_DONE;
      if (state_r == REQ_DONE)
        rsp_err <= PDA_ERR_TNU;
      else if (bus.ack)
        rsp_err <= bus.err_tnu ? PDA_ERR_TNU : (bus.err_width ? PDA_ERR_WIDTH : PDA_ERR_NONE);
    end
  end

  // Word consumed on its handshake; refused command dropped whole
  assign cmd_ready = (state_r == REQ_BEAT && bus.ack) || state_r == REQ_DONE;

endmodule

// >>> pda_rep.sv
`timescale 1ns/1ns
`include "pda_map.svh"
// Word FIFO between the replier and its user
module pda_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = `PDA_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // Pointers wrap freely, so only a power-of-two depth works
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin
    $error("pda_fifo: DEPTH must be a power of two of at least 2");
  end

  assign in_ready  = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_r];

  // Storage written without reset; pointers guard its contents
  always_ff @(posedge clk) begin
    if (push)
      mem[wr_r] <= in_data;
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push)
        wr_r <= wr_r + 1'b1;
      if (pop)
        rd_r <= rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module pda_rep
  import pda_pkg::*;
#(
  parameter int AGENT_WIDTH = `PDA_AGENT_WIDTH,
  parameter int MSG_WORDS   = `PDA_MSG_WORDS,
  parameter int FIFO_DEPTH  = `PDA_FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  pda_if.replier           bus,
  input  wire logic        chk_en,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [31:0]      out_data,
  output logic [3:0]       out_lanes,
  output logic             out_last,
  output logic [1:0]       out_space,
  output logic             err_pulse,
  output logic [1:0]       err_code
);
  import pda_pkg::*;

  typedef enum logic {REP_IDLE, REP_BEAT} pda_rep_state_type;

  localparam int CW = $clog2(MSG_WORDS + 1) + 1;

  pda_rep_state_type state_r;
  pda_pat_type       pat;
  logic              tnu_nxt;
  logic              wid_nxt;
  logic              tnu_r;
  logic              wid_r;
  logic [3:0]        lanes_r;
  logic [1:0]        space_r;
  logic [CW-1:0]     words_r;
  logic              over;
  logic              take;
  logic              fin_ready;
  logic [38:0]       fin_data;
  logic [38:0]       fout_data;

  // 24-bit agents are not supported at all
  if (AGENT_WIDTH != 8 && AGENT_WIDTH != 16 && AGENT_WIDTH != 32) begin
    $error("pda_rep: AGENT_WIDTH must be 8, 16 or 32");
  end
  if (MSG_WORDS < 1) begin
    $error("pda_rep: MSG_WORDS must be at least 1");
  end

  // Request phase decode, combinational, latched below
  always_comb begin
    pat     = pda_decode(bus.space, bus.wsel, bus.alvl);
    tnu_nxt = !pat.legal;
    if (bus.seq && !pat.seq_ok)
      tnu_nxt = 1'b1;
    wid_nxt = 1'b0;
    // Width errors only exist in memory and I/O space
    if (chk_en && (bus.space == `PDA_SPACE_MEM || bus.space == `PDA_SPACE_IO)) begin
      if (AGENT_WIDTH == 8)
        wid_nxt = pat.lanes != `PDA_LANES_B0 && pat.lanes != `PDA_LANES_B1;
      else if (AGENT_WIDTH == 16)
        wid_nxt = pat.lanes[2];
      if (AGENT_WIDTH != 32 && pat.need32)
        wid_nxt = 1'b1;
    end
  end

  // Decoded checks held for the whole transfer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tnu_r   <= 1'b0;
      wid_r   <= 1'b0;
      lanes_r <= `PDA_LANES_NONE;
      space_r <= `PDA_SPACE_MEM;
    end else if (bus.req && state_r == REP_IDLE) begin
      tnu_r   <= tnu_nxt;
      wid_r   <= wid_nxt;
      lanes_r <= pat.lanes;
      space_r <= bus.space;
    end
  end

  // Message longer than agreed is not understood
  assign over = space_r == `PDA_SPACE_MSG && words_r >= CW'(MSG_WORDS);

  // A beat is answered once data has room, or at once when in error
  assign take = state_r == REP_BEAT && bus.dvalid && !bus.ack &&
                (tnu_r || wid_r || over || fin_ready);

  // Transfer state and message word count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= REP_IDLE;
      words_r <= '0;
    end else begin
      if (state_r == REP_IDLE && bus.req) begin
        state_r <= REP_BEAT;
        words_r <= '0;
      end else if (take) begin
        words_r <= words_r + 1'b1;
        if (bus.eoc || tnu_r || wid_r || over)
          state_r <= REP_IDLE;
      end
    end
  end

  // Handshake and agent error lines, one cycle per beat
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.ack       <= 1'b0;
      bus.err_tnu   <= 1'b0;
      bus.err_width <= 1'b0;
    end else begin
      bus.ack       <= take;
      // Not understood outranks a width error
      bus.err_tnu   <= take && (tnu_r || over);
      bus.err_width <= take && !tnu_r && !over && wid_r;
    end
  end

  // Error report to the local user
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_pulse <= 1'b0;
      err_code  <= PDA_ERR_NONE;
    end else begin
      err_pulse <= take && (tnu_r || wid_r || over);
      if (take)
        err_code <= (tnu_r || over) ? PDA_ERR_TNU : (wid_r ? PDA_ERR_WIDTH : PDA_ERR_NONE);
    end
  end

  // Lanes outside the pattern are dropped; space travels with its word
  assign fin_data = {space_r, bus.eoc, lanes_r, bus.ad & pda_byte_mask(lanes_r)};

  pda_fifo #(
    .WIDTH (39),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (take && !tnu_r && !wid_r && !over),
    .in_ready  (fin_ready),
    .in_data   (fin_data),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fout_data)
  );

  assign out_last  = fout_data[36];
  assign out_lanes = fout_data[35:32];
  assign out_data  = fout_data[31:0];
  // Space stays with the word, so it stands until popped
  assign out_space = fout_data[38:37];

endmodule

// >>> pda_chk_sva.sv
`timescale 1ns/1ns
// Watches the wire between the two agents
module pda_chk #(
  parameter int AGENT_WIDTH = 32
) (
  input logic        clk,
  input logic        rst_n,
  input logic        req,
  input logic [1:0]  space,
  input logic [1:0]  wsel,
  input logic [1:0]  alvl,
  input logic        seq,
  input logic [31:0] addr,
  input logic        dvalid,
  input logic [31:0] ad,
  input logic        eoc,
  input logic        ack,
  input logic        err_tnu,
  input logic        err_width
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Bit 1 legal, bit 0 also fit for sequential use; levels, not address bits
  function automatic logic [1:0] pat_ok(input logic [1:0] sp, ws, al);
    if (sp == 2'h1)
      return (ws == 2'h0) ? 2'h3 : 2'h0;
    if (sp == 2'h0)
      return (ws == 2'h3 && al == 2'h3) ? 2'h2 : 2'h0;
    case (ws)
      2'h3: return 2'h3;
      2'h2: return al[0] ? 2'h3 : {al[1], 1'b0};
      2'h1: return (al == 2'h2) ? 2'h2 : 2'h0;
      default: return (al == 2'h3) ? 2'h3 : 2'h0;
    endcase
  endfunction

  // Request strobe, then a waiting beat
  sequence req_s;
    req ##1 !req;
  endsequence
  sequence wait_s;
    dvalid && !ack;
  endsequence

  legal_req_a: assert property (req |-> pat_ok(space, wsel, alvl) >= 2'h2)
    else $error("illegal pattern requested");
  seq_req_a: assert property (req && seq |-> pat_ok(space, wsel, alvl) == 2'h3)
    else $error("sequential use of a single-only pattern");
  addr_lvl_a: assert property (req |-> alvl == ~addr[1:0])
    else $error("address levels disagree with address");
  req_beat_a: assert property (req_s |-> ##[0:2] dvalid)
    else $error("no beat after request");
  beat_hold_a: assert property (wait_s |=> dvalid && $stable(ad) && $stable(eoc))
    else $error("beat dropped or changed before ack");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (ack |-> $past(dvalid))
    else $error("ack without a beat");
  err_ack_a: assert property (err_tnu || err_width |-> ack)
    else $error("error without ack");
  tnu_first_a: assert property (err_tnu |-> !err_width)
    else $error("two errors on one beat");
  no_width_a: assert property (ack && AGENT_WIDTH == 32 |-> !err_width)
    else $error("width error from a full-width agent");
  fields_hold_a: assert property (dvalid |-> $stable(space) && $stable(wsel))
    else $error("request fields moved during beats");
  msg_addr_a: assert property (req && space == 2'h1 |-> addr[31:16] == 16'h0000)
    else $error("message address wider than two agent IDs");
endmodule

// >>> psb_data_alignment_width_check_tb_top.sv
`timescale 1ns/1ns
module psb_data_alignment_width_check_tb_top;
  import pda_pkg::*;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [1:0]  cmd_space = 2'h3;
  logic [1:0]  cmd_wsel = 2'h3;
  logic [31:0] cmd_addr = 32'h0;
  logic        cmd_seq = 1'b0;
  logic [31:0] cmd_data = 32'h0;
  logic        cmd_last = 1'b1;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [1:0]  rsp_err;
  logic        out_valid;
  logic        out_ready = 1'b0;
  logic [31:0] out_data;
  logic [3:0]  out_lanes;
  logic        out_last;
  logic [1:0]  out_space;
  logic        chk2 = 1'b1;
  logic        rep2_pulse;
  logic [1:0]  rep2_code;
  logic        hold = 1'b0;
  logic        stall;
  logic [7:0]  i;
  logic [31:0] rnd;
  integer      seed = 32'h6fb0;
  int          err_total = 0;
  int          n_compared = 0;
  logic [38:0] exp_q[$];
  // Broken and legal requests for the 16-bit replier: {space, width, levels, check on, {tnu, width}}
  logic [8:0]  tab2 [13] = '{9'h1fc, 9'h1dc, 9'h155, 9'h150, 9'h1b5, 9'h19d, 9'h186,
                             9'h1ae, 9'h084, 9'h0de, 9'h07c, 9'h076, 9'h01e};

  pda_if b1 ();
  pda_if b2 ();
  pda_req pda_req_i (.clk, .rst_n, .bus(b1), .cmd_valid, .cmd_ready, .cmd_space, .cmd_wsel,
                     .cmd_addr, .cmd_seq, .cmd_data, .cmd_last, .rsp_valid, .rsp_err);
  pda_rep pda_rep_i (.clk, .rst_n,
    .bus(b1), .chk_en(1'b1), .out_valid, .out_ready, .out_data, .out_lanes, .out_last,
    .out_space, .err_pulse(), .err_code());
  // Second replier only faces the bench, so its user side just drains
  pda_rep #(.AGENT_WIDTH(16)) pda_rep_i2 (.clk, .rst_n,
    .bus(b2), .chk_en(chk2), .out_valid(), .out_ready(1'b1), .out_data(), .out_lanes(),
    .out_last(), .out_space(), .err_pulse(rep2_pulse), .err_code(rep2_code));
  pda_chk pda_chk_i (.clk, .rst_n, .req(b1.req), .space(b1.space),
    .wsel(b1.wsel), .alvl(b1.alvl), .seq(b1.seq), .addr(b1.addr), .dvalid(b1.dvalid),
    .ad(b1.ad), .eoc(b1.eoc), .ack(b1.ack), .err_tnu(b1.err_tnu), .err_width(b1.err_width));

  always #2 clk = ~clk;

  // Far side stalls at random, and on every cycle while the buffer fills
  always @(posedge clk) out_ready <= !hold && (($random(seed) & 3) != 0);

  task automatic check(input string what, input logic [39:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic give_up;
    err_total++;
    $display("Error wait expected done seen timeout");
    test_done();
  endtask

  // Every popped word must be the oldest one expected
  always @(negedge clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0)
        check("fifo_extra", 1, 0);
      else
        check("fifo_out", {out_data, out_lanes, out_last, out_space}, exp_q.pop_front());
    end
  end

  // {legal, lanes} from the address bits themselves
  function automatic logic [4:0] pat(input logic [1:0] sp, ws, a, input logic sq);
    logic [3:0] ln;
    logic       so;
    ln = 4'h0;
    so = 1'b0;
    if (sp[1] && ws == 2'h3)
      ln = a[0] ? 4'h2 : 4'h1;
    if (sp[1] && ws == 2'h2)
      ln = !a[0] ? 4'h3 : (!a[1] ? 4'h6 : 4'h0);
    if (sp[1] && ws == 2'h1 && a == 2'h1)
      ln = 4'h7;
    if (sp[1] && ws == 2'h0 && a == 2'h0)
      ln = 4'hf;
    if (sp == 2'h1 && ws == 2'h0)
      ln = 4'hf;
    if (sp == 2'h0 && ws == 2'h3 && a == 2'h0)
      ln = 4'h1;
    so = sp != 2'h0 && (ln != 4'h6) && (ln != 4'h7);
    return {ln != 4'h0 && (!sq || so), ln};
  endfunction

  // One word through the requester; refused words expect a local error
  task automatic send(input logic [1:0] sp, ws, input logic [31:0] a, d,
                      input logic sq, lst, bad);
    logic [4:0]  p;
    logic [31:0] m;
    logic        rd;
    logic        rs;
    int          n;
    p = pat(sp, ws, a[1:0], sq);
    m = {{8{p[3]}}, {8{p[2]}}, {8{p[1]}}, {8{p[0]}}};
    if (p[4] && !bad)
      exp_q.push_back({(d << (p[0] ? 0 : 8)) & m, p[3:0], lst, sp});
    rd = 1'b0;
    rs = 1'b0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_space <= sp;
    cmd_wsel <= ws;
    cmd_addr <= a;
    cmd_seq <= sq;
    cmd_data <= d;
    cmd_last <= lst;
    for (n = 0; n < 300 && !(rd && rs); n++) begin
      @(negedge clk);
      rd |= cmd_ready === 1'b1;
      if (rsp_valid === 1'b1) begin
        rs = 1'b1;
        check("rsp_err", rsp_err, (p[4] && !bad) ? 2'h0 : 2'h1);
      end
      @(posedge clk);
      if (rd)
        cmd_valid <= 1'b0;
    end
    if (!(rd && rs))
      give_up();
  endtask

  // Bench plays requester on the second wire
  task automatic req2(input logic [1:0] sp, ws, al, input logic ck);
    @(posedge clk);
    b2.req <= 1'b1;
    b2.space <= sp;
    b2.wsel <= ws;
    b2.alvl <= al;
    b2.addr <= {30'h0, ~al};
    b2.seq <= sp == 2'h1;
    chk2 <= ck;
    @(posedge clk);
    b2.req <= 1'b0;
  endtask

  task automatic beat2(input logic lst, input logic [1:0] e);
    int n;
    @(posedge clk);
    b2.dvalid <= 1'b1;
    b2.ad <= $random(seed);
    b2.eoc <= lst;
    for (n = 0; n < 100 && b2.ack !== 1'b1; n++)
      @(negedge clk);
    if (n == 100)
      give_up();
    check("err2", {b2.err_tnu, b2.err_width}, e);
    check("err2_code", {rep2_pulse, rep2_code}, {|e, e[1] ? 2'h1 : {e[0], 1'b0}});
    @(posedge clk);
    b2.dvalid <= 1'b0;
  endtask

  task automatic drain;
    int n;
    for (n = 0; n < 500 && exp_q.size() != 0; n++)
      @(posedge clk);
    if (n == 500)
      give_up();
  endtask

  initial begin
    b2.req = 1'b0;
    b2.space = 2'h3;
    b2.wsel = 2'h3;
    b2.alvl = 2'h3;
    b2.seq = 1'b0;
    b2.addr = 32'h0;
    b2.dvalid = 1'b0;
    b2.ad = 32'h0;
    b2.eoc = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // Every space, width, address-bit and sequential code, random address and data
    for (i = 0; i < 128; i++) begin
      rnd = $random(seed);
      send(i[6:5], i[4:3], {rnd[31:2], i[2:1]}, $random(seed), i[0], 1'b1, 1'b0);
    end
    $display("test codes finished");
    // Three words against a two-word receiver: the third is refused
    send(2'h1, 2'h0, 32'h0, 32'h0011_a5c3, 1'b1, 1'b0, 1'b0);
    send(2'h1, 2'h0, 32'h0, $random(seed), 1'b1, 1'b0, 1'b0);
    send(2'h1, 2'h0, 32'h0, $random(seed), 1'b1, 1'b1, 1'b1);
    $display("test message finished");
    // Fill the buffer with the far side stalled, then release it
    drain();
    hold = 1'b1;
    @(posedge clk);
    for (i = 0; i < 16; i++)
      send(2'h3, 2'h0, 32'h0, $random(seed), 1'b0, 1'b1, 1'b0);
    fork
      send(2'h3, 2'h0, 32'h4, 32'h5a5a_0f0f, 1'b0, 1'b1, 1'b0);
      begin
        stall = 1'b0;
        repeat (20) @(negedge clk) stall |= cmd_ready === 1'b1;
        check("full_stall", stall, 1'b0);
        hold = 1'b0;
      end
    join
    drain();
    $display("test fill finished");
    // Broken and narrow patterns at a 16-bit replier
    for (i = 0; i < 13; i++) begin
      req2(tab2[i][8:7], tab2[i][6:5], tab2[i][4:3], tab2[i][2]);
      beat2(1'b1, tab2[i][1:0]);
    end
    req2(2'h1, 2'h0, 2'h0, 1'b1);
    beat2(1'b0, 2'h0);
    beat2(1'b0, 2'h0);
    beat2(1'b1, 2'h2);
    $display("test errors finished");
    test_done();
  end
endmodule
